// ===== core/muting_map.svh
// Timing constants and field positions for the muting sequence controller
`ifndef MUTING_MAP_SVH
`define MUTING_MAP_SVH

`define CLK_HZ              100000000
`define TICK_MS_CYCLES      (`CLK_HZ / 1000)
`define PAIRING_WINDOW_MS   2000
`define ACTIVATE_MS         100
`define RESTORE_MS          5000
`define BARRIER_CLEAR_MS    2000
`define MAX_MUTE_HOURS      24
`define MAX_MUTE_MS         (`MAX_MUTE_HOURS * 3600 * 1000)
`define ACTIVATE_DELAY_MS   1
`define DUR_SEL_0_MS        (1 * 3600 * 1000)
`define DUR_SEL_1_MS        (2 * 3600 * 1000)
`define DUR_SEL_2_MS        (8 * 3600 * 1000)
`define SENSOR_BIT_0        0
`define SENSOR_BIT_1        1

`endif

// ===== core/muting_pkg.sv
// Types for the muting sequence controller
package muting_pkg;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_PAIRING,
      ST_MUTED,
      ST_RELEASE,
      ST_WAIT_CLEAR,
      ST_LOCKOUT
   } mute_state_t;
endpackage

// ===== core/ms_tick_divider.sv
// Millisecond enable pulse divider
`timescale 1ns/1ps
`include "muting_map.svh"
module ms_tick_divider
#(
   parameter int unsigned TICK_CYCLES = `TICK_MS_CYCLES
)
(
   input  wire logic clk,
   input  wire logic arst_n,
   output logic      tick_ms
);
   localparam int unsigned DIV = TICK_CYCLES;
   logic [16:0] count;

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         count   <= 17'h00000;
         tick_ms <= 1'b0;
      end
      else if (count == 17'(DIV - 1))
      begin
         count   <= 17'h00000;
         tick_ms <= 1'b1;
      end
      else
      begin
         count   <= count + 17'h00001;
         tick_ms <= 1'b0;
      end
   end
endmodule // ms_tick_divider

// ===== core/muting_sequence_controller.sv
// Muting supervisor that gates the paired safety outputs
// Functional notes
// (R1) Both sensors active within 2 s window
// (R2) Wrong order refuses muting as sequence error; code still mutes if both sensors rise in one cycle while barrier broken
// (R3) Fixed model caps muting at 24 hours
// (R4) Sensors drive high while active
// (R5) Optical sensor high when beam interrupted
// (R6) Suspend protection within 100 ms of last sensor
// (R7) Either sensor release ends muting
// (R8) Protection restored within 5 s of release
// (R9) Muting ends 2 s after barrier clears
// (R10) Timing or sequence fault drives outputs off
// (R11) Override recovers from muting fault
// (R12) No new cycle before previous terminated
// (R13) Selectable model takes limit from inputs
// (R14) Same sensors start and end muting
// (R15) Faulty sensor detection locks out
// (R16) Override needs both channels asserted
// (R17) Outputs switch together; unmuted break trips
`timescale 1ns/1ps
`include "muting_map.svh"
module muting_sequence_controller
#(
   parameter int unsigned TICK_CYCLES  = `TICK_MS_CYCLES,
   parameter int unsigned PAIRING_MS   = `PAIRING_WINDOW_MS,
   parameter int unsigned RESTORE_MS   = `RESTORE_MS,
   parameter int unsigned CLEAR_MS     = `BARRIER_CLEAR_MS,
   parameter int unsigned MAX_MUTE_MS  = `MAX_MUTE_MS,
   parameter int unsigned SEL0_MS      = `DUR_SEL_0_MS,
   parameter int unsigned SEL1_MS      = `DUR_SEL_1_MS,
   parameter int unsigned SEL2_MS      = `DUR_SEL_2_MS
)
(
   input  wire logic       clk,
   input  wire logic       arst_n,
   input  wire logic [1:0] mute_sensor,
   input  wire logic       barrier_broken,
   input  wire logic       override_0,
   input  wire logic       override_1,
   input  wire logic       duration_select_model,
   input  wire logic [1:0] duration_select,
   output logic            safety_out_1,
   output logic            safety_out_2,
   output logic            muting_active,
   output logic            sequence_fault
);
   localparam logic [31:0] ACT_MS = `ACTIVATE_DELAY_MS;

   muting_pkg::mute_state_t state;
   logic        tick_ms;
   logic [31:0] timer_ms;
   logic [1:0]  prev_sensor;
   logic        prev_barrier;
   logic        suspended;
   logic        override_ok;
   logic [31:0] limit_ms;
   logic        sensor_rise;
   logic        any_active;
   logic        both_active;

   ms_tick_divider
   #(
      .TICK_CYCLES (TICK_CYCLES)
   )
   u_div
   (
      .clk     (clk),
      .arst_n  (arst_n),
      .tick_ms (tick_ms)
   );

   assign override_ok = override_0 & override_1; // R16
   assign any_active  = |mute_sensor; // R4 R5
   assign both_active = &mute_sensor; // R14
   assign sensor_rise = |(mute_sensor & ~prev_sensor);

   // Muting limit per model
   always_comb
   begin
      if (!duration_select_model)
         limit_ms = 32'(MAX_MUTE_MS); // R3
      else
      begin
         unique case (duration_select) // R13
            2'h0: limit_ms = 32'(SEL0_MS);
            2'h1: limit_ms = 32'(SEL1_MS);
            2'h2: limit_ms = 32'(SEL2_MS);
            2'h3: limit_ms = 32'(MAX_MUTE_MS);
         endcase
      end
   end

   // Edge history
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         prev_sensor  <= 2'h0;
         prev_barrier <= 1'b0;
      end
      else
      begin
         prev_sensor  <= mute_sensor;
         prev_barrier <= barrier_broken;
      end
   end

   // Sequence state and timer
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state          <= muting_pkg::ST_IDLE;
         timer_ms       <= 32'h00000000;
         suspended      <= 1'b0;
         sequence_fault <= 1'b0;
      end
      else
      begin
         unique case (state)
            muting_pkg::ST_IDLE:
            begin
               suspended <= 1'b0;
               timer_ms  <= 32'h00000000;
               if (both_active && sensor_rise)
                  state <= muting_pkg::ST_MUTED; // R1
               else if (any_active && sensor_rise)
               begin
                  if (barrier_broken)
                  begin
                     state          <= muting_pkg::ST_LOCKOUT; // R2
                     sequence_fault <= 1'b1; // R2
                  end
                  else
                     state <= muting_pkg::ST_PAIRING;
               end
               else if (both_active)
               begin
                  state          <= muting_pkg::ST_LOCKOUT; // R15
                  sequence_fault <= 1'b1;
               end
            end
            muting_pkg::ST_PAIRING:
            begin
               if (tick_ms)
                  timer_ms <= timer_ms + 32'h00000001;
               if (!any_active)
                  state <= muting_pkg::ST_IDLE;
               else if (barrier_broken)
               begin
                  state          <= muting_pkg::ST_LOCKOUT; // R2
                  sequence_fault <= 1'b1;
               end
               else if (both_active)
               begin
                  state    <= muting_pkg::ST_MUTED; // R1
                  timer_ms <= 32'h00000000;
               end
               else if (timer_ms >= 32'(PAIRING_MS))
               begin
                  state          <= muting_pkg::ST_LOCKOUT; // R1
                  sequence_fault <= 1'b1; // R10
               end
            end
            muting_pkg::ST_MUTED:
            begin
               if (tick_ms)
                  timer_ms <= timer_ms + 32'h00000001;
               if (timer_ms >= ACT_MS)
                  suspended <= 1'b1; // R6
               if (!both_active)
               begin
                  state     <= muting_pkg::ST_RELEASE; // R7
                  suspended <= 1'b0; // R8
                  timer_ms  <= 32'h00000000;
               end
               else if (timer_ms >= limit_ms)
               begin
                  state          <= muting_pkg::ST_LOCKOUT; // R3
                  suspended      <= 1'b0;
                  sequence_fault <= 1'b1; // R10
               end
               else if (prev_barrier && !barrier_broken)
               begin
                  state     <= muting_pkg::ST_WAIT_CLEAR;
                  timer_ms  <= 32'h00000000;
               end
            end
            muting_pkg::ST_WAIT_CLEAR:
            begin
               if (tick_ms)
                  timer_ms <= timer_ms + 32'h00000001;
               if (!both_active || timer_ms >= 32'(CLEAR_MS))
               begin
                  state     <= muting_pkg::ST_RELEASE; // R9
                  suspended <= 1'b0;
                  timer_ms  <= 32'h00000000;
               end
            end
            muting_pkg::ST_RELEASE:
            begin
               if (tick_ms)
                  timer_ms <= timer_ms + 32'h00000001;
               if (!any_active)
                  state <= muting_pkg::ST_IDLE; // R12
               else if (timer_ms >= 32'(RESTORE_MS))
               begin
                  state          <= muting_pkg::ST_LOCKOUT; // R15
                  sequence_fault <= 1'b1;
               end
            end
            muting_pkg::ST_LOCKOUT:
            begin
               suspended <= 1'b0;
               if (override_ok)
               begin
                  state          <= muting_pkg::ST_RELEASE; // R11
                  sequence_fault <= 1'b0;
                  timer_ms       <= 32'h00000000;
               end
            end
         endcase
      end
   end

   // Paired outputs
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         safety_out_1  <= 1'b0;
         safety_out_2  <= 1'b0;
         muting_active <= 1'b0;
      end
      else
      begin
         muting_active <= suspended;
         if (state == muting_pkg::ST_LOCKOUT && !override_ok)
         begin
            safety_out_1 <= 1'b0; // R10
            safety_out_2 <= 1'b0;
         end
         else
         begin
            safety_out_1 <= !barrier_broken || suspended || override_ok; // R17
            safety_out_2 <= !barrier_broken || suspended || override_ok; // R17
         end
      end
   end
endmodule // muting_sequence_controller

// ===== bench/mute_sensors.sv
// Model of the two external muting sensors
`timescale 1ns/1ps
module mute_sensors
(
   input  wire logic [1:0] want,
   output logic      [1:0] mute_sensor
);
   // Active sensor holds its line high, a clear one holds it low
   assign mute_sensor = want;
endmodule // mute_sensors

// ===== bench/mute_chk_sva.sv
// Concurrent checks on the muting controller ports
`timescale 1ns/1ps
module mute_chk
(
   input wire logic       clk,
   input wire logic       arst_n,
   input wire logic [1:0] mute_sensor,
   input wire logic       barrier_broken,
   input wire logic       override_0,
   input wire logic       override_1,
   input wire logic       safety_out_1,
   input wire logic       safety_out_2,
   input wire logic       muting_active,
   input wire logic       sequence_fault
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   sequence rel_s;
      muting_active && !(&mute_sensor) && barrier_broken ##1 barrier_broken;
   endsequence
   a_outs_paired:
      assert property (safety_out_1 == safety_out_2) else $error("outputs differ");
   a_break_trips:
      assert property (mute_sensor == 2'h0 && barrier_broken && !override_0 ##1
         mute_sensor == 2'h0 && barrier_broken && !override_0 |=> !safety_out_1) else $error("no trip");
   a_fault_off:
      assert property ($rose(sequence_fault) |-> ##[0:1] !safety_out_1) else $error("fault left on");
   a_fault_holds:
      assert property (sequence_fault && !(override_0 && override_1) |=> sequence_fault)
      else $error("fault dropped");
   a_mute_pair:
      assert property ($rose(muting_active) |-> $past(mute_sensor, 2) == 2'h3) else $error("unpaired mute");
   a_release_ends:
      assert property (muting_active && !(&mute_sensor) |-> ##[1:3] !muting_active) else $error("mute kept");
   a_release_restores:
      assert property (rel_s |-> ##[0:2] !safety_out_1) else $error("not restored");
   a_break_first:
      assert property ($rose(mute_sensor[0]) && barrier_broken && !muting_active |-> ##[1:3] sequence_fault)
      else $error("order fault missed");
endmodule // mute_chk
bind muting_sequence_controller mute_chk i_chk (.clk(clk), .arst_n(arst_n), .mute_sensor(mute_sensor),
   .barrier_broken(barrier_broken), .override_0(override_0), .override_1(override_1),
   .safety_out_1(safety_out_1), .safety_out_2(safety_out_2), .muting_active(muting_active),
   .sequence_fault(sequence_fault));

// ===== bench/muting_sequence_controller_tb.sv
// Bench for the muting sequence controller
`timescale 1ns/1ps
module muting_sequence_controller_tb;
   localparam int T = 10;
   localparam int P = 2000;
   logic clk = 0, arst_n = 0, bb = 0, o0 = 0, o1 = 0, dm = 0;
   logic [1:0] want = 0, ds = 0, ms;
   logic so1, so2, ma, sf;
   logic [31:0] rnd = 32'hA9230C8D;
   logic [2:0] exp_q[$];
   int fail_count = 0, checks_done = 0, lim;
   event ev;
   mute_sensors i_sens (.want(want), .mute_sensor(ms));
   muting_sequence_controller #(.TICK_CYCLES(T), .MAX_MUTE_MS(8),
      .SEL0_MS(5), .SEL1_MS(6), .SEL2_MS(7)) i_dut (.clk(clk), .arst_n(arst_n), .mute_sensor(ms),
      .barrier_broken(bb), .override_0(o0), .override_1(o1), .duration_select_model(dm),
      .duration_select(ds), .safety_out_1(so1), .safety_out_2(so2), .muting_active(ma),
      .sequence_fault(sf));
   initial forever #5 clk = ~clk;
   function automatic logic [31:0] lfsr(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic wt(int c);
      repeat (c) @(negedge clk);
   endtask
   task automatic chk(logic [2:0] e);
      wt(3);
      exp_q.push_back(e);
      -> ev;
   endtask
   always @(ev)
   begin : mon
      logic [2:0] e;
      e = exp_q.pop_front();
      checks_done++;
      if (e !== {so1, ma, sf})
      begin
         fail_count++;
         $display("ERROR out_mute_fault expected %b seen %b", e, {so1, ma, sf});
      end
   end
   task automatic recover();
      bb = 0;
      o0 = 1;
      o1 = 1;
      chk(3'h4);
      {o0, o1, want} = 0;
      chk(3'h4);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial
   begin
      wt(2);
      arst_n = 1;
      bb = 1;
      chk(3'h0);
      bb = 0;
      want = 2'h1;
      wt(T);
      want = 2'h3;
      wt(3 * T);
      chk(3'h6);
      bb = 1;
      chk(3'h6);
      want = 2'h2;
      chk(3'h0);
      {want, bb} = 0;
      chk(3'h4);
      $display("test valid_mute done");
      want = 2'h1;
      wt((P + 2) * T);
      chk(3'h1);
      recover();
      $display("test late_pair done");
      bb = 1;
      wt(2);
      want = 2'h1;
      chk(3'h1);
      bb = 0;
      o0 = 1;
      chk(3'h1);
      recover();
      $display("test wrong_order done");
      rnd = lfsr(rnd);
      {dm, ds} = rnd[2:0];
      lim = (!dm || ds == 2'h3) ? 8 : 5 + ds;
      want = 2'h3;
      wt(lim * T - 3 * T / 2);
      chk(3'h6);
      wt(5 * T);
      chk(3'h1);
      want = 0;
      chk(3'h1);
      $display("test mute_limit done");
      wt(1);
      tally_and_finish();
   end
endmodule // muting_sequence_controller_tb
